/* rtl/fpurc_top.v */
`timescale 1ns/1ps
`include "fpurc_map.vh"
// How it works
// - supply-detect reset holds logic, ignores instructions
// - write-class commands ignored during hold-off delay
// - reads accepted once select delay passed
// - power-up: standby, flags and locks cleared
// - low supply disables all operations
// - reset pulse interrupts running array cycle
// - any reset pulse clears all lock bits
// - reset in decode or standby restarts logic
// - reset during array cycle restarts logic
// - status write finishes before reset completes
// - delivered array all ones, status zero
// - cycle-active flag high while cycle runs
// - deep sleep cleared by power loss
module fpurc_top #(
	// hold-off length in cycles; shorten for simulation
	// cycles per millisecond are the clock rate in MHz times one thousand
	parameter HOLDOFF_CYC = `FPURC_HOLDOFF_MIN_MS * `FPURC_CLK_MHZ * 1000,
	// status write length in cycles
	parameter STATUS_WR_CYC = 1000
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_rst,
	// supply detect: high while supply below write inhibit level
	input wire i_supply_low,
	// supply at operating minimum
	input wire i_supply_ok,
	// reset pin and chip select, active low
	input wire i_reset_pin_n,
	input wire i_select_n,
	// decoded command strobe from the serial front end
	input wire i_cmd_valid,
	input wire [`FPURC_CLS_W-1:0] i_cmd_class,
	// array cycle finished (self-timed engine)
	input wire i_array_done,
	// lock bit writes
	input wire i_lock_wr,
	input wire [1:0] i_lock_data,
	// status
	output reg o_logic_rst,
	output reg o_cmd_accept,
	output reg o_cmd_start,
	output reg o_write_latch_flag,
	output reg o_cycle_active_flag,
	output reg o_status_wr_active,
	output reg o_array_abort,
	output reg o_deep_sleep,
	output reg [1:0] o_lock_bits,
	output wire o_holdoff_active,
	output wire o_select_ready
);
	// ----------------------------------------------------------------
	// constants
	// ----------------------------------------------------------------
	localparam CW = `FPURC_CNT_W;
	localparam SEL_CYC = `FPURC_SELECT_DELAY_US * `FPURC_CLK_MHZ;
	// one-hot states
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_ARRAY = 4'b0010;
	localparam [3:0] ST_STATUS = 4'b0100;
	localparam [3:0] ST_RSTWAIT = 4'b1000;

	reg [3:0] state; // cycle state
	reg [3:0] next_state;
	reg [CW-1:0] swr_cnt; // status write countdown
	reg pin_q; // previous reset pin level
	wire holdoff_done;
	wire select_done;
	wire pin_fall;
	wire sup_rst;

	// supply-detect reset and external reset merge
	assign sup_rst = i_rst || i_supply_low;
	assign pin_fall = pin_q && !i_reset_pin_n;

	// ----------------------------------------------------------------
	// power-up delays
	// ----------------------------------------------------------------
	// hold-off counted from supply-detect release
	fpurc_delay #(.W(CW), .LEN(HOLDOFF_CYC[CW-1:0])) u_holdoff (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_hold(i_supply_low),
		.o_done(holdoff_done)
	);
	// select delay from supply reaching its minimum
	fpurc_delay #(.W(CW), .LEN(SEL_CYC[CW-1:0])) u_select (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_hold(i_supply_low || !i_supply_ok),
		.o_done(select_done)
	);
	assign o_holdoff_active = !holdoff_done;
	assign o_select_ready = select_done;

	// command gate: reads after select delay, writes after hold-off
	function allow;
		input [`FPURC_CLS_W-1:0] cls;
		input sleeping;
		input busy;
		begin
			if (sleeping)
				allow = (cls == `FPURC_CLS_WAKE) && !busy;
			else if (cls == `FPURC_CLS_READ)
				allow = 1'b1;
			else if (cls == `FPURC_CLS_WRITE_ENABLE_CMD || cls == `FPURC_CLS_ARRAY)
				allow = holdoff_done && !busy;
			else if (cls == `FPURC_CLS_STATUS)
				allow = holdoff_done && !busy;
			else
				allow = !busy;
		end
	endfunction

	// ----------------------------------------------------------------
	// cycle state machine
	// ----------------------------------------------------------------
	// next state: reset pin aborts array, waits out status write
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (o_cmd_start && i_cmd_class == `FPURC_CLS_ARRAY)
					next_state = ST_ARRAY;
				else if (o_cmd_start && i_cmd_class == `FPURC_CLS_STATUS)
					next_state = ST_STATUS;
			end
			ST_ARRAY: begin
				if (pin_fall || i_array_done)
					next_state = ST_IDLE;
			end
			ST_STATUS: begin
				if (swr_cnt == {CW{1'b0}})
					next_state = ST_IDLE;
				else if (pin_fall)
					next_state = ST_RSTWAIT;
			end
			ST_RSTWAIT: begin
				if (swr_cnt == {CW{1'b0}})
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// command acceptance, combinational handshake
	always @* begin
		o_cmd_accept = i_cmd_valid && !o_logic_rst && select_done
			&& !i_select_n
			&& allow(i_cmd_class, o_deep_sleep, state != ST_IDLE);
		o_cmd_start = o_cmd_accept && !i_select_n;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// flags, locks, sleep; supply reset forces the power-on state
	always @(posedge i_clk_sys) begin
		if (sup_rst) begin
			state <= ST_IDLE;
			swr_cnt <= {CW{1'b0}};
			pin_q <= 1'b1;
			o_logic_rst <= 1'b1;
			// every status flag leaves reset at zero
			o_write_latch_flag <= 1'b0;
			o_cycle_active_flag <= 1'b0;
			o_status_wr_active <= 1'b0;
			o_array_abort <= 1'b0;
			o_deep_sleep <= 1'b0;
			o_lock_bits <= 2'b00;
		end else begin
			state <= next_state;
			pin_q <= i_reset_pin_n;
			o_array_abort <= (state == ST_ARRAY) && pin_fall;
			// internal logic held while reset pin low, except status write
			// a pin pulse seen during a status write is served late: the
			// logic restarts for one cycle once the write time has run out
			o_logic_rst <= (!i_reset_pin_n && (next_state != ST_STATUS)
				&& (next_state != ST_RSTWAIT))
				|| (state == ST_RSTWAIT && next_state == ST_IDLE);
			// status write countdown
			if (state == ST_IDLE && next_state == ST_STATUS)
				swr_cnt <= STATUS_WR_CYC[CW-1:0];
			else if (swr_cnt != {CW{1'b0}})
				swr_cnt <= swr_cnt - {{(CW-1){1'b0}}, 1'b1};
			o_cycle_active_flag <= (next_state != ST_IDLE);
			o_status_wr_active <= (next_state == ST_STATUS)
				|| (next_state == ST_RSTWAIT);
			// lock bits: reset pin clears them at once
			if (!i_reset_pin_n)
				o_lock_bits <= 2'b00;
			else if (i_lock_wr && !o_logic_rst)
				o_lock_bits <= i_lock_data;
			// write latch
			if (!i_reset_pin_n || (state != ST_IDLE && next_state == ST_IDLE))
				o_write_latch_flag <= 1'b0;
			else if (o_cmd_start && i_cmd_class == `FPURC_CLS_WRITE_ENABLE_CMD)
				o_write_latch_flag <= 1'b1;
			// deep sleep
			if (!i_reset_pin_n)
				o_deep_sleep <= 1'b0;
			else if (o_cmd_start && i_cmd_class == `FPURC_CLS_SLEEP)
				o_deep_sleep <= 1'b1;
			else if (o_cmd_start && i_cmd_class == `FPURC_CLS_WAKE)
				o_deep_sleep <= 1'b0;
		end
	end
endmodule

/* rtl/fpurc_map.vh */
`ifndef FPURC_MAP_VH
`define FPURC_MAP_VH
// ----------------------------------------------------------------
// timing figures and encodings
// ----------------------------------------------------------------
// least select delay after valid supply, microseconds
`define FPURC_SELECT_DELAY_US 30
// write hold-off delay window, milliseconds
`define FPURC_HOLDOFF_MIN_MS 1
`define FPURC_HOLDOFF_MAX_MS 10
// system clock rate, MHz
`define FPURC_CLK_MHZ 200
// counter width for long delays
`define FPURC_CNT_W 24
// command class codes on i_cmd_class
`define FPURC_CLS_W 3
`define FPURC_CLS_READ 3'h0
`define FPURC_CLS_WRITE_ENABLE_CMD 3'h1
`define FPURC_CLS_ARRAY 3'h2
`define FPURC_CLS_STATUS 3'h3
`define FPURC_CLS_SLEEP 3'h4
`define FPURC_CLS_WAKE 3'h5
`define FPURC_CLS_OTHER 3'h6
// erased byte value and cleared status
`define FPURC_ERASED_BYTE 8'hFF
`define FPURC_STATUS_CLEAR 8'h00
`endif

/* rtl/fpurc_delay.v */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// down counter: o_done high once LEN cycles passed since i_hold fell
// ----------------------------------------------------------------
module fpurc_delay #(
	parameter W = 24,
	parameter [W-1:0] LEN = 1
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_rst,
	// control
	input wire i_hold, // restart and hold while high
	// status
	output reg o_done
);
	reg [W-1:0] count; // cycles still to wait

	// count down; hold keeps the counter loaded
	always @(posedge i_clk_sys) begin
		if (i_rst || i_hold) begin
			count <= LEN;
			o_done <= 1'b0;
		end else if (count != {W{1'b0}}) begin
			count <= count - {{(W-1){1'b0}}, 1'b1};
			o_done <= (count == {{(W-1){1'b0}}, 1'b1});
		end else begin
			o_done <= 1'b1;
		end
	end
endmodule

/* test/fpurc_props.sv */
`timescale 1ns/1ps
`include "fpurc_map.vh"
// ---
// sequencing checks on the top ports
// ---
module fpurc_props (
	input wire i_clk_sys, i_rst, i_supply_low, i_reset_pin_n,
	input wire i_select_n, i_cmd_valid, i_array_done,
	input wire [`FPURC_CLS_W-1:0] i_cmd_class,
	input wire o_logic_rst, o_cmd_accept, o_write_latch_flag,
	input wire o_cycle_active_flag, o_status_wr_active, o_array_abort,
	input wire o_deep_sleep, o_holdoff_active, o_select_ready,
	input wire [1:0] o_lock_bits
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	// classes that the hold-off must refuse
	wire wr = i_cmd_class == `FPURC_CLS_WRITE_ENABLE_CMD ||
		i_cmd_class == `FPURC_CLS_ARRAY || i_cmd_class == `FPURC_CLS_STATUS;
	accept_gate_a: assert property (o_cmd_accept |-> i_cmd_valid &&
		!i_select_n && o_select_ready && !o_logic_rst) else $error("accept");
	holdoff_wr_a: assert property (o_holdoff_active && wr |-> !o_cmd_accept)
		else $error("holdoff");
	supply_rst_a: assert property (i_supply_low |=> o_logic_rst)
		else $error("supply");
	pin_lock_a: assert property (!i_reset_pin_n |=> o_lock_bits == 2'b00)
		else $error("locks");
	array_abort_a: assert property ($fell(i_reset_pin_n) &&
		o_cycle_active_flag && !o_status_wr_active |=> o_array_abort &&
		o_logic_rst && !o_cycle_active_flag) else $error("abort");
	status_hold_a: assert property ($fell(i_reset_pin_n) &&
		o_status_wr_active |=> !o_logic_rst && o_status_wr_active)
		else $error("status");
	cycle_done_a: assert property (o_cycle_active_flag && i_array_done &&
		i_reset_pin_n && !o_status_wr_active |=> !o_cycle_active_flag &&
		!o_write_latch_flag) else $error("cycle");
	power_up_a: assert property ($fell(i_supply_low) |->
		(o_holdoff_active && !o_write_latch_flag && !o_cycle_active_flag &&
		!o_deep_sleep && o_lock_bits == 2'b00) [*3]) else $error("power");
endmodule
bind fpurc_top fpurc_props u_props (.*);

/* test/fpurc_host.sv */
`timescale 1ns/1ps
// ---
// host side: chip select and reset pin
// ---
module fpurc_host (
	input wire i_clk_sys,
	input wire i_supply_ok,
	input wire i_want_sel,
	input wire i_pulse_rst,
	output wire o_select_n,
	output wire o_reset_pin_n
);
	reg [12:0] cnt = 13'h0000; // cycles since supply valid
	// restart on supply loss, stop just past the select delay
	always @(posedge i_clk_sys) begin
		if (!i_supply_ok) begin
			cnt <= 13'h0000;
		end else if (cnt <= 13'h1770) begin
			cnt <= cnt + 13'h0001;
		end
	end
	// bench keeps i_want_sel up through a pulse, so select stays low
	assign o_select_n = !(i_want_sel && cnt > 13'h1770);
	assign o_reset_pin_n = i_supply_ok && !i_pulse_rst;
endmodule

/* test/testbench.sv */
`timescale 1ns/1ps
`include "fpurc_map.vh"
module testbench;
	reg i_clk_sys, i_rst, i_supply_low, i_supply_ok, i_cmd_valid;
	reg i_array_done, i_lock_wr, want_sel, pulse_rst;
	reg [2:0] i_cmd_class;
	reg [1:0] i_lock_data;
	wire i_select_n, i_reset_pin_n, o_logic_rst, o_cmd_accept, o_array_abort;
	wire o_write_latch_flag, o_cycle_active_flag, o_status_wr_active;
	wire o_deep_sleep, o_holdoff_active, o_select_ready;
	wire [1:0] o_lock_bits;
	integer n_errors, checks, k;
	fpurc_host u_fpurc_host (.i_clk_sys, .i_supply_ok, .i_want_sel(want_sel),
		.i_pulse_rst(pulse_rst), .o_select_n(i_select_n),
		.o_reset_pin_n(i_reset_pin_n));
	fpurc_top #(.HOLDOFF_CYC(7000), .STATUS_WR_CYC(20)) u_fpurc_top (.*,
		.o_cmd_start());
	initial begin
		i_clk_sys = 1'b0;
		forever #2.5 i_clk_sys = ~i_clk_sys;
	end
	task chk(input [7:0] got, input [7:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("[ERR] %0t %h %h", $time, got, exp);
			end
		end
	endtask
	task final_report;
		begin
			$display("errors %0d checks %0d", n_errors, checks);
			if (n_errors == 0 && checks > 0) $display("TB: PASS");
			else $display("TB: FAIL");
			$finish;
		end
	endtask
	// one command; accept is judged before the edge that takes it
	task cmd(input [2:0] c, input e);
		begin
			@(posedge i_clk_sys);
			i_cmd_valid <= 1'b1;
			i_cmd_class <= c;
			#1 chk(o_cmd_accept, e);
			@(posedge i_clk_sys);
			i_cmd_valid <= 1'b0;
			#1;
		end
	endtask
	// reset pin pulse, judged one edge after the fall
	task pin(input a);
		begin
			@(posedge i_clk_sys);
			pulse_rst <= 1'b1;
			@(posedge i_clk_sys);
			#1 chk({o_array_abort, o_logic_rst, o_lock_bits}, {a, a, 2'b00});
			@(posedge i_clk_sys);
			pulse_rst <= 1'b0;
			#1;
		end
	endtask
	task s_power;
		begin
			i_supply_low <= 1'b0;
			i_supply_ok <= 1'b1;
			want_sel <= 1'b1;
			@(posedge i_clk_sys);
			#1 chk(o_holdoff_active, 1);
			cmd(`FPURC_CLS_READ, 0);
			for (k = 0; k < 6100 && o_select_ready !== 1'b1; k = k + 1) #5;
			cmd(`FPURC_CLS_READ, 1);
			cmd(`FPURC_CLS_WRITE_ENABLE_CMD, 0);
			cmd(`FPURC_CLS_ARRAY, 0);
			for (k = 0; k < 1100 && o_holdoff_active !== 1'b0; k = k + 1) #5;
			cmd(`FPURC_CLS_WRITE_ENABLE_CMD, 1);
		end
	endtask
	task s_array;
		begin
			@(posedge i_clk_sys);
			i_lock_wr <= 1'b1;
			i_lock_data <= 2'b11;
			@(posedge i_clk_sys);
			i_lock_wr <= 1'b0;
			cmd(`FPURC_CLS_ARRAY, 1);
			chk({o_lock_bits, o_cycle_active_flag}, 7);
			@(posedge i_clk_sys);
			i_array_done <= 1'b1;
			@(posedge i_clk_sys);
			i_array_done <= 1'b0;
			#1 chk({o_cycle_active_flag, o_write_latch_flag}, 0);
			cmd(`FPURC_CLS_WRITE_ENABLE_CMD, 1);
			cmd(`FPURC_CLS_ARRAY, 1);
			pin(1);
		end
	endtask
	task s_status;
		begin
			#15;
			cmd(`FPURC_CLS_WRITE_ENABLE_CMD, 1);
			cmd(`FPURC_CLS_STATUS, 1);
			pin(0);
			for (k = 0; k < 40 && o_logic_rst !== 1'b1; k = k + 1) #5;
			chk({k > 5, o_status_wr_active, o_logic_rst}, 5);
		end
	endtask
	task s_drop;
		begin
			for (k = 0; k < 40 && o_logic_rst !== 1'b0; k = k + 1) #5;
			cmd(`FPURC_CLS_SLEEP, 1);
			cmd(`FPURC_CLS_READ, 0);
			chk(o_deep_sleep, 1);
			@(posedge i_clk_sys);
			i_supply_low <= 1'b1;
			i_supply_ok <= 1'b0;
			@(posedge i_clk_sys);
			i_supply_low <= 1'b0;
			i_supply_ok <= 1'b1;
			#1 chk({o_logic_rst, o_deep_sleep, o_holdoff_active}, 5);
		end
	endtask
	initial begin
		i_rst = 1'b1;
		i_supply_low = 1'b1;
		{i_supply_ok, i_cmd_valid, i_array_done, i_lock_wr} = 4'h0;
		{want_sel, pulse_rst, i_cmd_class, i_lock_data} = 7'h00;
		n_errors = 0;
		checks = 0;
		repeat (4) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		s_power;
		s_array;
		s_status;
		s_drop;
		final_report;
	end
	// hang guard, well past the longest expected run
	initial begin
		#100000;
		n_errors = n_errors + 1;
		final_report;
	end
endmodule
